// file: hw/cap_addr_gen.sv
// Address generation, prefetch hint and compressed subword access unit
//
// Functional notes
// RULE1: Write prefetch target is base address plus sign-extended 12-bit offset.
// RULE2: Write prefetch is valid only when offset low five bits are zero.
// RULE3: Prefetch authority is base capability, or default data capability.
// RULE4: Shift-add adds second source shifted by 1, 2 or 3 to address.
// RULE5: Capability shift-add clears tag if unrepresentable or source sealed.
// RULE6: Word-unsigned shift-add exists only on 64-bit cores, zero-extends source.
// RULE7: Shift-by-four add increments address by second source times sixteen.
// RULE8: Shift-by-four word-unsigned add uses zero-extended low word.
// RULE9: Compressed subword loads expand to 32-bit forms; authority by mode.
// RULE10: Compressed stores expand to 32-bit forms; no write permission faults.
// RULE11: Authority with cleared tag raises tag violation.
// RULE12: Sealed authority raises seal violation.
// RULE13: Any touched byte outside bounds raises length violation.
// RULE14: Load authority without read permission raises permission violation.
// RULE15: Failed check reports data fault type and matching cause code.
// RULE16: Capability-mode push and pop move full capabilities.
// RULE17: Capability-mode double moves transfer full capabilities.
// RULE18: Saved specifiers 0-1 map to x8-x9, 2-7 to x18-x23.
// RULE19: Shift-add representability uses shared bounds compression check.
//
// Implementation choices: the APB register port and the address map.
`include "cap_regs.svh"
`default_nettype none
module cap_addr_gen #(
  parameter int XLEN = 64,
  parameter int REP_LOG2 = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire cap_pkg::op_kind_e op_kind,
  input wire logic [2:0] op_funct3,
  input wire logic [11:0] op_imm,
  input wire logic op_half,
  input wire logic op_unsigned,
  input wire logic [2:0] op_rd_c,
  input wire logic [2:0] op_rs1_c,
  input wire logic [2:0] op_rs2_c,
  input wire logic [2:0] sreg_a,
  input wire logic [2:0] sreg_b,
  input wire logic [XLEN-1:0] src1_addr,
  input wire logic [XLEN-1:0] src2,
  input wire logic base_tag,
  input wire logic base_sealed,
  input wire logic base_perm_r,
  input wire logic base_perm_w,
  input wire logic [XLEN-1:0] base_lo,
  input wire logic [XLEN-1:0] base_hi,
  input wire logic ddc_tag,
  input wire logic ddc_sealed,
  input wire logic ddc_perm_r,
  input wire logic ddc_perm_w,
  input wire logic [XLEN-1:0] ddc_lo,
  input wire logic [XLEN-1:0] ddc_hi,
  output logic res_valid,
  output logic [XLEN-1:0] res_addr,
  output logic res_tag,
  output logic res_is_cap,
  output logic illegal,
  output logic pf_valid,
  output logic [XLEN-1:0] pf_addr,
  output logic pf_auth_ddc,
  output logic mem_valid,
  output logic [XLEN-1:0] mem_addr,
  output logic mem_store,
  output logic mem_half,
  output logic mem_unsigned,
  output logic [31:0] exp_instr,
  output logic fault_valid,
  output cap_pkg::fault_type_t fault_type,
  output cap_pkg::cause_t fault_cause,
  output logic [4:0] sreg_x_a,
  output logic [4:0] sreg_x_b,
  output logic xfer_cap
);
  initial begin
    if (XLEN != 32 && XLEN != 64) begin
      $error("XLEN must be 32 or 64");
    end
    if (REP_LOG2 < 1 || REP_LOG2 >= XLEN) begin
      $error("REP_LOG2 out of range");
    end
  end

  localparam logic IS64 = (XLEN == 64);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // RULE18: saved register specifier mapping
  function automatic logic [4:0] sreg_map(input logic [2:0] s);
    if (s < 3'h2) begin
      sreg_map = `SREG_LOW_BASE + {2'h0, s};
    end else begin
      sreg_map = `SREG_HIGH_BASE + {2'h0, s};
    end
  endfunction

  function automatic logic [4:0] creg(input logic [2:0] r);
    creg = {`CREG_PREFIX, r};
  endfunction

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic cap_mode;
  logic flt_sticky;
  cap_pkg::fault_type_t flt_type_q;
  cap_pkg::cause_t flt_cause_q;
  logic [31:0] flt_addr_q;
  logic apb_done;
  logic apb_wr;
  logic hit;
  logic [31:0] rd_word;
  logic new_fault;
  logic [XLEN-1:0] acc_addr;
  cap_pkg::cause_t auth_cause;

  assign apb_done = psel & penable & pready;
  assign apb_wr = apb_done & pwrite;

  always_comb begin
    rd_word = 32'h0;
    hit = 1'b1;
    case (paddr)
      `CTRL_OFFSET: begin
        rd_word[`CTRL_CAP_MODE_BIT] = cap_mode;
      end
      `FAULT_OFFSET: begin
        rd_word[`FAULT_VALID_BIT] = flt_sticky;
        rd_word[`FAULT_TYPE_MSB:`FAULT_TYPE_LSB] = flt_type_q;
        rd_word[`FAULT_CAUSE_MSB:`FAULT_CAUSE_LSB] = flt_cause_q;
      end
      `FAULT_ADDR_OFFSET: begin
        rd_word = flt_addr_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // One wait state: answer in the second access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_word;
        pslverr <= ~hit;
      end else begin
        prdata <= 32'h0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_mode <= `CTRL_CAP_MODE_RESET;
    end else if (ce && apb_wr && paddr == `CTRL_OFFSET) begin
      cap_mode <= pwdata[`CTRL_CAP_MODE_BIT];
    end
  end

  // A new fault wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_sticky <= 1'b0;
      flt_type_q <= `TYPE_NONE;
      flt_cause_q <= `CAUSE_NONE;
      flt_addr_q <= 32'h0;
    end else if (ce) begin
      if (new_fault) begin
        flt_sticky <= 1'b1;
        flt_type_q <= `TYPE_DATA_FAULT;
        flt_cause_q <= auth_cause;
        flt_addr_q <= acc_addr[31:0];
      end else if (apb_wr && paddr == `FAULT_OFFSET &&
                   pwdata[`FAULT_VALID_BIT]) begin
        flt_sticky <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------------
  logic is_sh;
  logic is_uw;
  logic fn3_ok;
  logic [2:0] sh_amt;
  logic [XLEN-1:0] sa_sum;
  logic sa_tag;
  logic [XLEN-1:0] pf_target;
  logic [XLEN-1:0] sum_ref;
  logic [31:0] src2_w;
  logic is_mem;
  logic auth_fault;
  logic [31:0] next_exp;
  logic next_illegal;

  assign is_uw = (op_kind == cap_pkg::OP_SHADD_UW) ||
                 (op_kind == cap_pkg::OP_SH4ADD_UW);
  assign is_sh = (op_kind == cap_pkg::OP_SHADD) || is_uw ||
                 (op_kind == cap_pkg::OP_SH4ADD);
  assign fn3_ok = (op_funct3 == `FN3_SH1) || (op_funct3 == `FN3_SH2) ||
                  (op_funct3 == `FN3_SH3);
  assign is_mem = (op_kind == cap_pkg::OP_C_LOAD) ||
                  (op_kind == cap_pkg::OP_C_STORE);
  assign src2_w = src2[31:0];

  // RULE4: funct3 010/100/110 give shifts 1/2/3
  // RULE7: shift-by-four variants
  always_comb begin
    sh_amt = {1'b0, op_funct3[2:1]};
    if (op_kind == cap_pkg::OP_SH4ADD ||
        op_kind == cap_pkg::OP_SH4ADD_UW) begin
      sh_amt = `SH4_AMOUNT;
    end
  end

  shift_add_unit #(
    .XLEN(XLEN),
    .REP_LOG2(REP_LOG2)
  ) u_shift_add (
    .src1_addr(src1_addr),
    .src2(src2),
    .amount(sh_amt),
    .word_unsigned(is_uw),
    .cap_mode(cap_mode),
    .src_tag(base_tag),
    .src_sealed(base_sealed),
    .bound_base(base_lo),
    .bound_top(base_hi),
    .sum(sa_sum),
    .sum_tag(sa_tag)
  );

  // RULE1: sign-extended offset onto base address
  assign pf_target = src1_addr + {{(XLEN-12){op_imm[11]}}, op_imm};
  assign acc_addr = src1_addr + {{(XLEN-12){1'b0}}, op_imm};

  // RULE9: authority is base capability or default data capability
  subword_auth #(
    .XLEN(XLEN)
  ) u_auth (
    .auth_tag(cap_mode ? base_tag : ddc_tag),
    .auth_sealed(cap_mode ? base_sealed : ddc_sealed),
    .auth_perm_r(cap_mode ? base_perm_r : ddc_perm_r),
    .auth_perm_w(cap_mode ? base_perm_w : ddc_perm_w),
    .auth_base(cap_mode ? base_lo : ddc_lo),
    .auth_top(cap_mode ? base_hi : ddc_hi),
    .addr(acc_addr),
    .half(op_half),
    .is_store(op_kind == cap_pkg::OP_C_STORE),
    .fault(auth_fault),
    .cause(auth_cause)
  );

  assign new_fault = op_valid & is_mem & auth_fault;

  // RULE9: load expansion to 32-bit form
  // RULE10: store expansion to 32-bit form
  always_comb begin
    next_exp = 32'h0;
    if (op_kind == cap_pkg::OP_C_LOAD) begin
      next_exp = {op_imm, creg(op_rs1_c),
                  op_half ? (op_unsigned ? `F3_LHU : `F3_LH) : `F3_LBU,
                  creg(op_rd_c), `OPC_LOAD};
    end else if (op_kind == cap_pkg::OP_C_STORE) begin
      next_exp = {op_imm[11:5], creg(op_rs2_c), creg(op_rs1_c),
                  op_half ? `F3_SH : `F3_SB, op_imm[4:0], `OPC_STORE};
    end
  end

  // RULE2: prefetch needs zero low offset bits
  // RULE6: word-unsigned forms only on 64-bit cores
  always_comb begin
    next_illegal = 1'b0;
    case (op_kind)
      cap_pkg::OP_PREFETCH_W: next_illegal = op_imm[4:0] != `PF_LOW_ZERO;
      cap_pkg::OP_SHADD: next_illegal = ~fn3_ok;
      cap_pkg::OP_SHADD_UW: next_illegal = ~fn3_ok | ~IS64;
      cap_pkg::OP_SH4ADD_UW: next_illegal = ~IS64;
      default: next_illegal = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal <= 1'b0;
      res_valid <= 1'b0;
      res_addr <= '0;
      res_tag <= 1'b0;
      res_is_cap <= 1'b0;
    end else if (ce) begin
      illegal <= op_valid & next_illegal;
      res_valid <= op_valid & is_sh & ~next_illegal;
      // RULE8: shift-by-four on unsigned word
      if (op_valid && is_sh) begin
        res_addr <= sa_sum;
        res_tag <= sa_tag;
        res_is_cap <= cap_mode;
      end
    end
  end

  // RULE3: prefetch authority by mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_valid <= 1'b0;
      pf_addr <= '0;
      pf_auth_ddc <= 1'b0;
    end else if (ce) begin
      pf_valid <= op_valid & (op_kind == cap_pkg::OP_PREFETCH_W) &
                  ~next_illegal;
      if (op_valid && op_kind == cap_pkg::OP_PREFETCH_W) begin
        pf_addr <= pf_target;
        pf_auth_ddc <= ~cap_mode;
      end
    end
  end

  // RULE15: data fault type with cause code
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem_addr <= '0;
      mem_store <= 1'b0;
      mem_half <= 1'b0;
      mem_unsigned <= 1'b0;
      exp_instr <= 32'h0;
      fault_valid <= 1'b0;
      fault_type <= `TYPE_NONE;
      fault_cause <= `CAUSE_NONE;
    end else if (ce) begin
      mem_valid <= op_valid & is_mem & ~auth_fault;
      fault_valid <= new_fault;
      fault_type <= new_fault ? `TYPE_DATA_FAULT : `TYPE_NONE;
      fault_cause <= new_fault ? auth_cause : `CAUSE_NONE;
      if (op_valid && is_mem) begin
        mem_addr <= acc_addr;
        mem_store <= op_kind == cap_pkg::OP_C_STORE;
        mem_half <= op_half;
        mem_unsigned <= op_unsigned | (op_kind == cap_pkg::OP_C_STORE);
        exp_instr <= next_exp;
      end
    end
  end

  // RULE16: push and pop move capabilities in capability mode
  // RULE17: double moves transfer capabilities
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sreg_x_a <= 5'h0;
      sreg_x_b <= 5'h0;
      xfer_cap <= 1'b0;
    end else if (ce && op_valid && op_kind == cap_pkg::OP_ZCMP) begin
      sreg_x_a <= sreg_map(sreg_a);
      sreg_x_b <= sreg_map(sreg_b);
      xfer_cap <= cap_mode;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  assign sum_ref = src1_addr + XLEN'(src2 << sh_amt);

  a_prefetch_addr: assert property ( // RULE1
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_PREFETCH_W &&
    op_imm[4:0] == 5'h0 |=> pf_valid && pf_addr == $past(pf_target))
    else $error("prefetch target wrong");

  a_prefetch_illegal: assert property ( // RULE2
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_PREFETCH_W &&
    op_imm[4:0] != 5'h0 |=> illegal && !pf_valid)
    else $error("bad prefetch accepted");

  a_prefetch_auth: assert property ( // RULE3
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_PREFETCH_W
    |=> pf_auth_ddc == !$past(cap_mode))
    else $error("prefetch authority wrong");

  a_shadd_sum: assert property ( // RULE4
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_SHADD && fn3_ok
    |=> res_valid && res_addr == $past(sum_ref))
    else $error("shift add sum wrong");

  a_sealed_untag: assert property ( // RULE5
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && is_sh && (base_sealed || !cap_mode) |=> !res_tag)
    else $error("tag kept on sealed source");

  a_uw_zero_ext: assert property ( // RULE6
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_SHADD_UW && fn3_ok && IS64
    |=> res_addr == $past(src1_addr) +
        XLEN'({{(XLEN-32){1'b0}}, $past(src2_w)} << $past(sh_amt)))
    else $error("unsigned word add wrong");

  a_sh4_sum: assert property ( // RULE7
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_SH4ADD
    |=> res_valid && res_addr == $past(src1_addr) +
        XLEN'($past(src2) << 4))
    else $error("shift four add wrong");

  a_tag_fault: assert property ( // RULE11
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && is_mem && !(cap_mode ? base_tag : ddc_tag)
    |=> fault_valid && !mem_valid && fault_cause == `CAUSE_TAG &&
        fault_type == `TYPE_DATA_FAULT ##1 !ce || flt_sticky)
    else $error("tag fault not reported");

  a_store_perm: assert property ( // RULE10
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_C_STORE && cap_mode &&
    base_tag && !base_sealed && !base_perm_w
    |=> fault_valid && fault_cause == `CAUSE_PERM)
    else $error("store permission not checked");

  a_sreg_map: assert property ( // RULE18
    @(posedge core_clk) disable iff (!rst_n)
    ce && op_valid && op_kind == cap_pkg::OP_ZCMP && sreg_a == 3'h2
    |=> sreg_x_a == 5'h12)
    else $error("saved register map wrong");
endmodule
`default_nettype wire

// file: hw/shift_add_unit.sv
// Shift-and-add address generation with representability tag check
`include "cap_regs.svh"
`default_nettype none
module shift_add_unit #(
  parameter int XLEN = 64,
  parameter int REP_LOG2 = 12
) (
  input wire logic [XLEN-1:0] src1_addr,
  input wire logic [XLEN-1:0] src2,
  input wire logic [2:0] amount,
  input wire logic word_unsigned,
  input wire logic cap_mode,
  input wire logic src_tag,
  input wire logic src_sealed,
  input wire logic [XLEN-1:0] bound_base,
  input wire logic [XLEN-1:0] bound_top,
  output logic [XLEN-1:0] sum,
  output logic sum_tag
);
  // Same window test as every other address-modifying operation
  function automatic logic rep_ok(input logic [XLEN-1:0] a,
                                  input logic [XLEN-1:0] lo,
                                  input logic [XLEN-1:0] hi);
    logic [XLEN:0] margin;
    // One bit wider so bounds near zero or the top never wrap
    margin = (XLEN+1)'(1) << REP_LOG2;
    rep_ok = ({1'b0, a} + margin >= {1'b0, lo}) &&
             ({1'b0, a} <= {1'b0, hi} + margin);
  endfunction

  logic [XLEN-1:0] operand;

  // RULE6: unsigned word operand
  always_comb begin
    operand = src2;
    if (word_unsigned) begin
      operand = {{(XLEN-32){1'b0}}, src2[31:0]};
    end
  end

  // RULE4: shifted add onto address
  assign sum = src1_addr + XLEN'(operand << amount);
  // RULE5: sealed or unrepresentable clears tag
  // RULE19: shared bounds compression check
  assign sum_tag = cap_mode & src_tag & ~src_sealed &
                   rep_ok(sum, bound_base, bound_top);
endmodule
`default_nettype wire

// file: hw/subword_auth.sv
// Authorisation checks for compressed byte and halfword accesses
`include "cap_regs.svh"
`default_nettype none
module subword_auth #(
  parameter int XLEN = 64
) (
  input wire logic auth_tag,
  input wire logic auth_sealed,
  input wire logic auth_perm_r,
  input wire logic auth_perm_w,
  input wire logic [XLEN-1:0] auth_base,
  input wire logic [XLEN-1:0] auth_top,
  input wire logic [XLEN-1:0] addr,
  input wire logic half,
  input wire logic is_store,
  output logic fault,
  output cap_pkg::cause_t cause
);
  logic [XLEN:0] last_excl;

  assign last_excl = {1'b0, addr} + (half ? (XLEN+1)'(2) : (XLEN+1)'(1));

  // Tag before seal before permission before bounds
  always_comb begin
    cause = `CAUSE_NONE;
    // RULE11: cleared tag
    if (!auth_tag) begin
      cause = `CAUSE_TAG;
    // RULE12: sealed authority
    end else if (auth_sealed) begin
      cause = `CAUSE_SEAL;
    // RULE10: store needs write permission
    end else if (is_store && !auth_perm_w) begin
      cause = `CAUSE_PERM;
    // RULE14: load needs read permission
    end else if (!is_store && !auth_perm_r) begin
      cause = `CAUSE_PERM;
    // RULE13: every touched byte in bounds
    end else if (addr < auth_base ||
                 last_excl > {1'b0, auth_top}) begin
      cause = `CAUSE_LENGTH;
    end
  end

  assign fault = (cause != `CAUSE_NONE);
endmodule
`default_nettype wire

// file: include/cap_pkg.sv
// Types shared by the address generation and subword access unit
`default_nettype none
package cap_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PREFETCH_W = 4'h1,
    OP_SHADD = 4'h2,
    OP_SHADD_UW = 4'h3,
    OP_SH4ADD = 4'h4,
    OP_SH4ADD_UW = 4'h5,
    OP_C_LOAD = 4'h6,
    OP_C_STORE = 4'h7,
    OP_ZCMP = 4'h8
  } op_kind_e;
  typedef logic [4:0] cause_t;
  typedef logic [3:0] fault_type_t;
endpackage
`default_nettype wire

// file: include/cap_regs.svh
// Register offsets, field positions and encoding constants for the unit
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH

`define CTRL_OFFSET 12'h000
`define FAULT_OFFSET 12'h004
`define FAULT_ADDR_OFFSET 12'h008

`define CTRL_CAP_MODE_BIT 0
`define CTRL_CAP_MODE_RESET 1'b1

`define FAULT_CAUSE_LSB 0
`define FAULT_CAUSE_MSB 4
`define FAULT_TYPE_LSB 8
`define FAULT_TYPE_MSB 11
`define FAULT_VALID_BIT 31

`define CAUSE_NONE 5'h00
`define CAUSE_TAG 5'h02
`define CAUSE_SEAL 5'h03
`define CAUSE_PERM 5'h08
`define CAUSE_LENGTH 5'h01
`define TYPE_NONE 4'h0
`define TYPE_DATA_FAULT 4'h1

`define FN3_SH1 3'h2
`define FN3_SH2 3'h4
`define FN3_SH3 3'h6
`define SH4_AMOUNT 3'h4
`define PF_LOW_ZERO 5'h00

`define SREG_LOW_BASE 5'h08
`define SREG_HIGH_BASE 5'h10
`define CREG_PREFIX 2'h1

`define OPC_LOAD 7'h03
`define OPC_STORE 7'h23
`define F3_LH 3'h1
`define F3_LHU 3'h5
`define F3_LBU 3'h4
`define F3_SH 3'h1
`define F3_SB 3'h0

`endif

// file: tb/cap_addr_gen_and_subword_access_tb.sv
// Self-checking bench for the address generation and subword unit
`default_nettype none
module cap_addr_gen_and_subword_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err_bit;
  logic [11:0] paddr, op_imm;
  logic [31:0] pwdata, prdata, rd, lf;
  logic op_valid, op_half, op_unsigned, illegal, xfer_cap, ce;
  logic res_is_cap, mem_half, mem_unsigned;
  logic [31:0] exp_instr;
  cap_pkg::op_kind_e op_kind;
  logic [2:0] op_funct3, op_rd_c, op_rs1_c, op_rs2_c, sreg_a, sreg_b;
  logic [63:0] src1_addr, src2, base_lo, base_hi, ddc_lo, ddc_hi, s2, e;
  logic base_tag, base_sealed, base_perm_r, base_perm_w;
  logic ddc_tag, ddc_sealed, ddc_perm_r, ddc_perm_w;
  logic res_valid, res_tag, pf_valid, pf_auth_ddc, mem_valid, mem_store;
  logic [63:0] res_addr, pf_addr, mem_addr;
  logic fault_valid;
  cap_pkg::fault_type_t fault_type;
  cap_pkg::cause_t fault_cause;
  logic [4:0] sreg_x_a, sreg_x_b;
  int err_count, n_compared, cyc, sh;
  typedef struct {int k; logic [64:0] v;} note_s;
  note_s q[$];
  logic [4:0] cs [7] = '{5'h00, 5'h02, 5'h03, 5'h08, 5'h01, 5'h08, 5'h00};

  cap_addr_gen #(.XLEN(64), .REP_LOG2(12)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_kind(op_kind), .op_funct3(op_funct3),
    .op_imm(op_imm), .op_half(op_half), .op_unsigned(op_unsigned),
    .op_rd_c(op_rd_c), .op_rs1_c(op_rs1_c), .op_rs2_c(op_rs2_c),
    .sreg_a(sreg_a), .sreg_b(sreg_b), .src1_addr(src1_addr), .src2(src2),
    .base_tag(base_tag), .base_sealed(base_sealed),
    .base_perm_r(base_perm_r), .base_perm_w(base_perm_w),
    .base_lo(base_lo), .base_hi(base_hi), .ddc_tag(ddc_tag),
    .ddc_sealed(ddc_sealed), .ddc_perm_r(ddc_perm_r),
    .ddc_perm_w(ddc_perm_w), .ddc_lo(ddc_lo), .ddc_hi(ddc_hi),
    .res_valid(res_valid), .res_addr(res_addr), .res_tag(res_tag),
    .res_is_cap(res_is_cap), .illegal(illegal), .pf_valid(pf_valid),
    .pf_addr(pf_addr), .pf_auth_ddc(pf_auth_ddc), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_store(mem_store), .mem_half(mem_half),
    .mem_unsigned(mem_unsigned), .exp_instr(exp_instr),
    .fault_valid(fault_valid),
    .fault_type(fault_type), .fault_cause(fault_cause),
    .sreg_x_a(sreg_x_a), .sreg_x_b(sreg_x_b), .xfer_cap(xfer_cap)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(string nm, logic [64:0] x, logic [64:0] s);
    n_compared++;
    if (x !== s) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic note(int k, logic [64:0] v);
    q.push_back('{k, v});
  endtask

  task automatic pop(int k, logic [64:0] s);
    note_s n;
    if (q.size() == 0) begin
      err_count++;
      $display("[FAIL] event expected none seen %0d", k);
    end else begin
      n = q.pop_front();
      cmp("event kind", n.k, k);
      cmp("event value", n.v, s);
    end
  endtask

  // Outputs pulse one cycle, so look mid-cycle
  always @(negedge core_clk) begin
    if (rst_n) begin
      if (res_valid) pop(0, {res_tag, res_addr});
      if (res_valid) pop(6, res_is_cap);
      if (pf_valid) pop(1, {pf_auth_ddc, pf_addr});
      if (fault_valid) pop(2, {56'h0, fault_type, fault_cause});
      if (illegal) pop(3, 65'h0);
      if (mem_valid) pop(4, {mem_store, mem_addr});
      if (mem_valid) pop(5, {mem_half, mem_unsigned, exp_instr});
    end
  end

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Answer taken at the very edge that completes the transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(cap_pkg::op_kind_e k);
    @(posedge core_clk);
    lf = nx(lf);
    op_kind <= k;
    {op_rd_c, op_rs1_c, op_rs2_c} <= lf[8:0];
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    lf = 32'h7126;
    {rst_n, psel, penable, pwrite, paddr, pwdata, op_valid} = '0;
    {op_funct3, op_imm, op_half, op_unsigned, sreg_a, sreg_b} = '0;
    {op_rd_c, op_rs1_c, op_rs2_c, src2, ddc_lo, base_lo} = '0;
    op_kind = cap_pkg::OP_NONE;
    ce = 1'b1;
    src1_addr = 64'h1000;
    base_hi = 64'h2000;
    ddc_hi = 64'h2000;
    {base_tag, base_perm_r, base_perm_w} = 3'h7;
    {ddc_tag, ddc_perm_r, ddc_perm_w, base_sealed, ddc_sealed} = 5'h1c;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    cmp("ctrl reset", {err_bit, rd}, 33'h1);
    apb(1'b0, 12'hffc, 32'h0);
    cmp("unmapped", {err_bit, rd}, 33'h100000000);
    for (int i = 0; i < 12; i++) begin
      sh = i >= 6 ? 4 : i % 3 + 1;
      lf = nx(lf);
      // Small operands keep some results representable
      s2 = i % 3 == 1 ? {56'h0, lf[7:0]} : {lf, nx(lf)};
      e = (i / 3) % 2 ? {32'h0, s2[31:0]} : s2;
      e = src1_addr + (e << sh);
      src2 <= s2;
      op_funct3 <= 3'(2 * (i % 3 + 1));
      base_sealed <= (i == 4);
      note(0, {i != 4 && e <= 64'h3000, e});
      note(6, 65'h1);
      go(i < 3 ? cap_pkg::OP_SHADD : i < 6 ? cap_pkg::OP_SHADD_UW :
         i < 9 ? cap_pkg::OP_SH4ADD : cap_pkg::OP_SH4ADD_UW);
    end
    op_funct3 <= 3'h3;
    note(3, 65'h0);
    go(cap_pkg::OP_SHADD);
    $display("shift-add test done");
    op_imm <= 12'hfe0;
    note(1, {1'b0, src1_addr - 64'h20});
    go(cap_pkg::OP_PREFETCH_W);
    op_imm <= 12'h021;
    note(3, 65'h0);
    go(cap_pkg::OP_PREFETCH_W);
    op_imm <= 12'h010;
    op_half <= 1'b1;
    for (int c = 0; c < 7; c++) begin
      base_tag <= c != 1;
      base_sealed <= c == 2;
      base_perm_r <= c != 3;
      base_perm_w <= c != 5;
      base_hi <= c == 4 ? 64'h1011 : 64'h2000;
      if (cs[c] == 5'h0) begin
        // Register fields that go() is about to drive
        e = nx(lf);
        s2 = c == 6 ? {2'h3, 7'h0, 2'h1, e[2:0], 2'h1, e[5:3], 8'h30, 7'h23}
             : {2'h2, 12'h010, 2'h1, e[5:3], 3'h1, 2'h1, e[8:6], 7'h03};
        note(4, {c == 6, 64'h1010});
        note(5, s2);
      end else
        note(2, {56'h0, 4'h1, cs[c]});
      go(c >= 5 ? cap_pkg::OP_C_STORE : cap_pkg::OP_C_LOAD);
    end
    apb(1'b0, 12'h004, 32'h0);
    cmp("fault reg", {err_bit, rd}, 33'h080000108);
    apb(1'b0, 12'h008, 32'h0);
    cmp("fault addr", {err_bit, rd}, 33'h000001010);
    for (int i = 0; i < 8; i++) begin
      sreg_a <= 3'(i);
      sreg_b <= 3'(7 - i);
      go(cap_pkg::OP_ZCMP);
      @(negedge core_clk);
      cmp("saved map", {xfer_cap, sreg_x_a, sreg_x_b},
          {1'b1, 5'(i < 2 ? 8 + i : 16 + i),
           5'(i > 5 ? 15 - i : 23 - i)});
    end
    $display("access test done");
    apb(1'b1, 12'h000, 32'h0);
    ddc_tag <= 1'b0;
    note(2, {56'h0, 4'h1, 5'h02});
    go(cap_pkg::OP_C_LOAD);
    op_imm <= 12'h000;
    note(1, {1'b1, src1_addr});
    go(cap_pkg::OP_PREFETCH_W);
    op_funct3 <= 3'h2;
    src2 <= 64'h5;
    note(0, {1'b0, src1_addr + 64'ha});
    note(6, 65'h0);
    go(cap_pkg::OP_SHADD);
    repeat (3) @(posedge core_clk);
    // Frozen clock enable must swallow the op
    ce <= 1'b0;
    go(cap_pkg::OP_PREFETCH_W);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp("queue empty", q.size(), 0);
    $display("legacy test done");
    final_report();
  end
endmodule
`default_nettype wire
